// >>> logic/oscsel_defines.svh
/*
 Constants of the oscillator select and clock output block: strap codes,
 start-up counts and the clock output ratio.
 Assumes inclusion by bare name from the block's modules and its bench.
*/
`ifndef OSCSEL_DEFINES_SVH
`define OSCSEL_DEFINES_SVH

// --------------------------------------------------------------------------
// Oscillator type strap codes
// --------------------------------------------------------------------------
`define OSCSEL_STRAP_LOW        3'h0
`define OSCSEL_STRAP_MED        3'h1
`define OSCSEL_STRAP_HIGH       3'h2
`define OSCSEL_STRAP_RC         3'h3
`define OSCSEL_STRAP_EXT        3'h4

// --------------------------------------------------------------------------
// Reset values and timing counts
// --------------------------------------------------------------------------
`define OSCSEL_DIVIDER_RESET    8'h00
`define OSCSEL_START_XTAL_CLKS  11'h400
`define OSCSEL_START_RCEXT_CLKS 11'h100
`define OSCSEL_CLKOUT_PH_LAST   2'h2

`endif

// >>> logic/oscsel_divider.sv
/*
 CPU clock divider: turns the oscillator clock into a CPU clock strobe.
 Assumes divider and halving inputs come from logic on core_clk.
*/
`timescale 1ns/1ps
`default_nettype none
`include "oscsel_defines.svh"

module oscsel_divider (
   input  wire logic       core_clk,
   input  wire logic       rst,
   input  wire logic       run,
   input  wire logic [7:0] cpuClockDivider,
   input  wire logic       machineCycleHalving,
   output logic            cpuTick
);

   logic [8:0] cnt_reg;
   logic [8:0] cnt_next;
   logic       tick_reg;
   logic       tick_next;
   logic [8:0] limit;

   // ------------------------------------------------------------------------
   // Count
   // ------------------------------------------------------------------------
   // Terminal count is divisor minus one; 2*(N+1)-1 is simply {N,1}.
   // The compare is >= so that a divider lowered mid-count takes at once.
   always_comb begin
      if (cpuClockDivider == `OSCSEL_DIVIDER_RESET) begin
         limit = machineCycleHalving ? 9'h001 : 9'h000;
      end else begin
         limit = {cpuClockDivider, 1'b1};
      end
      tick_next = run && (cnt_reg >= limit);
      if (!run || tick_next) begin
         cnt_next = 9'h000;
      end else begin
         cnt_next = cnt_reg + 9'h001;
      end
   end

   // Register the count and the strobe.
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         cnt_reg  <= 9'h000;
         tick_reg <= 1'b0;
      end else begin
         cnt_reg  <= cnt_next;
         tick_reg <= tick_next;
      end
   end

   assign cpuTick = tick_reg;

   // ------------------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------------------
   // Helper: cycles since the last strobe, and whether the setting held.
   logic [9:0] gap_reg;
   logic       same_reg;
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         gap_reg  <= 10'h000;
         same_reg <= 1'b0;
      end else begin
         gap_reg  <= tick_reg ? 10'h001 : gap_reg + 10'h001;
         same_reg <= tick_reg ? 1'b1 : (same_reg && run && $stable(cpuClockDivider)
                                        && $stable(machineCycleHalving));
      end
   end

   AST_DIV_PERIOD: assert property (@(posedge core_clk) disable iff (rst)
      (tick_reg && same_reg && run && $stable(cpuClockDivider)
       && $stable(machineCycleHalving)) |->
      (gap_reg == ((cpuClockDivider == 8'h00) ? (machineCycleHalving ? 10'h002 : 10'h001)
                   : {1'b0, cpuClockDivider, 1'b0} + 10'h002)))
      else $error("CPU strobe spacing differs from the divisor.");

   AST_DIV_STOPS: assert property (@(posedge core_clk) disable iff (rst)
      !run |=> !tick_reg)
      else $error("CPU strobe while the divider is stopped.");

endmodule
`default_nettype wire

// >>> logic/oscsel_pkg.sv
/*
 Types shared by the oscillator select and clock output block.
 Assumes nothing of its surroundings.
*/
package oscsel_pkg;

   // Oscillator option held in nonvolatile configuration.
   typedef enum logic [2:0] {
      OSC_LOW,
      OSC_MED,
      OSC_HIGH,
      OSC_RC,
      OSC_EXT
   } oscsel_osc_type;

   // Oscillator and execution state.
   typedef enum logic [1:0] {
      ST_LOAD,
      ST_RUN,
      ST_DOWN,
      ST_START
   } oscsel_state_type;

   // One shared pin: level driven and output enable.
   typedef struct packed {
      logic out;
      logic oe;
   } oscsel_pin_type;

endpackage

// >>> logic/oscsel_top.sv
/*
 Oscillator option select, power-down restart and clock output pin.
 Assumes core_clk is the running oscillator, straps are static from reset,
 and control inputs come from CPU logic on core_clk.
*/
`timescale 1ns/1ps
`default_nettype none
`include "oscsel_defines.svh"

// Operation
// - The oscillator option comes from configuration straps caught once after reset.
// - The on-chip RC option runs near 6 MHz and passes through the CPU clock divider.
// - Clock output exists only with the RC or external clock option.
// - With external clock input the second oscillator pin is handed to the port logic while the clock output is off.
// - With the enable set the clock output runs whenever the CPU clock divider runs (ST_RUN, not the restart count), Idle too.
// - The clock output frequency is one sixth of the CPU clock rate.
// - Divider zero gives full or half rate by the halving bit, N gives division by 2*(N+1).
// - Leaving power down waits 1024 clocks for crystals, 256 for RC or external clock.
module oscsel_top (
   input  wire logic                  core_clk,
   input  wire logic                  rst,
   input  wire logic [2:0]            oscTypeStrap,
   input  wire logic                  machineCycleHalving,
   input  wire logic [7:0]            cpuClockDivider,
   input  wire logic                  clockOutEnable,
   input  wire logic                  idleMode,
   input  wire logic                  powerDownReq,
   input  wire logic                  wakeReq,
   input  wire oscsel_pkg::oscsel_pin_type portDrive,
   output oscsel_pkg::oscsel_pin_type secondOscPin,
   output logic                       cpuTick,
   output logic                       cpuExecTick,
   output logic                       oscRunning,
   output logic                       secondPinIsPort,
   output logic                       clockOutActive
);

   oscsel_pkg::oscsel_state_type st_reg;
   oscsel_pkg::oscsel_state_type st_next;
   oscsel_pkg::oscsel_osc_type   oscType_reg;
   oscsel_pkg::oscsel_osc_type   oscType_next;
   oscsel_pkg::oscsel_pin_type   secPin_reg;
   oscsel_pkg::oscsel_pin_type   secPin_next;
   logic        halve_reg;
   logic        halve_next;
   logic [10:0] startCnt_reg;
   logic [10:0] startCnt_next;
   logic [10:0] startLimit;
   logic [1:0]  phase_reg;
   logic [1:0]  phase_next;
   logic        clkOut_reg;
   logic        clkOut_next;
   logic        clkOutAct_reg;
   logic        clkOutAllowed;
   logic        isCrystal;
   logic        isExt;
   logic        rcOrExt;

   // ------------------------------------------------------------------------
   // Option decode
   // ------------------------------------------------------------------------
   // Straps are not software registers, so nothing at run time can change them.
   always_comb begin
      isCrystal     = (oscType_reg == oscsel_pkg::OSC_LOW) || (oscType_reg == oscsel_pkg::OSC_MED)
                      || (oscType_reg == oscsel_pkg::OSC_HIGH);
      isExt         = (oscType_reg == oscsel_pkg::OSC_EXT);
      rcOrExt       = (oscType_reg == oscsel_pkg::OSC_RC) || isExt;
      startLimit    = isCrystal ? `OSCSEL_START_XTAL_CLKS : `OSCSEL_START_RCEXT_CLKS;
      // Idle is deliberately absent: the output keeps running through Idle.
      clkOutAllowed = clockOutEnable && rcOrExt && !isCrystal
                      && (st_reg == oscsel_pkg::ST_RUN);
   end

   // ------------------------------------------------------------------------
   // State machine
   // ------------------------------------------------------------------------
   // The strap is caught in the first cycle after reset release, never under
   // reset itself. Unknown strap codes fall back to the high crystal option.
   always_comb begin
      st_next       = st_reg;
      oscType_next  = oscType_reg;
      halve_next    = halve_reg;
      startCnt_next = 11'h000;
      case (st_reg)
         oscsel_pkg::ST_LOAD: begin
            halve_next = machineCycleHalving;
            case (oscTypeStrap)
               `OSCSEL_STRAP_LOW:  oscType_next = oscsel_pkg::OSC_LOW;
               `OSCSEL_STRAP_MED:  oscType_next = oscsel_pkg::OSC_MED;
               `OSCSEL_STRAP_RC:   oscType_next = oscsel_pkg::OSC_RC;
               `OSCSEL_STRAP_EXT:  oscType_next = oscsel_pkg::OSC_EXT;
               default:            oscType_next = oscsel_pkg::OSC_HIGH;
            endcase
            st_next = oscsel_pkg::ST_RUN;
         end
         oscsel_pkg::ST_RUN: begin
            if (powerDownReq) begin
               st_next = oscsel_pkg::ST_DOWN;
            end
         end
         oscsel_pkg::ST_DOWN: begin
            if (wakeReq) begin
               st_next = oscsel_pkg::ST_START;
            end
         end
         oscsel_pkg::ST_START: begin
            if (startCnt_reg == startLimit - 11'h001) begin
               st_next = oscsel_pkg::ST_RUN;
            end else begin
               startCnt_next = startCnt_reg + 11'h001;
            end
         end
         default: begin
            st_next = oscsel_pkg::ST_LOAD;
         end
      endcase
   end

   // Register the state group.
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         st_reg       <= oscsel_pkg::ST_LOAD;
         oscType_reg  <= oscsel_pkg::OSC_HIGH;
         halve_reg    <= 1'b0;
         startCnt_reg <= 11'h000;
      end else begin
         st_reg       <= st_next;
         oscType_reg  <= oscType_next;
         halve_reg    <= halve_next;
         startCnt_reg <= startCnt_next;
      end
   end

   // ------------------------------------------------------------------------
   // CPU clock divider
   // ------------------------------------------------------------------------
   // Every option, the RC one included, feeds the same divider.
   oscsel_divider u_divider (
      .core_clk            (core_clk),
      .rst                 (rst),
      .run                 (st_reg == oscsel_pkg::ST_RUN),
      .cpuClockDivider     (cpuClockDivider),
      .machineCycleHalving (halve_reg),
      .cpuTick             (cpuTick)
   );

   // ------------------------------------------------------------------------
   // Clock output and shared pin
   // ------------------------------------------------------------------------
   // Three CPU strobes per half period give one sixth of the CPU rate. When
   // the output is off it parks low so the next start is a clean rising edge.
   always_comb begin
      phase_next  = 2'h0;
      clkOut_next = 1'b0;
      if (clkOutAllowed) begin
         phase_next  = phase_reg;
         clkOut_next = clkOut_reg;
         if (cpuTick) begin
            if (phase_reg == `OSCSEL_CLKOUT_PH_LAST) begin
               phase_next  = 2'h0;
               clkOut_next = !clkOut_reg;
            end else begin
               phase_next = phase_reg + 2'h1;
            end
         end
      end
      if (clkOutAllowed) begin
         secPin_next = '{out: clkOut_next, oe: 1'b1};
      end else if (isExt) begin
         secPin_next = portDrive;
      end else begin
         secPin_next = '{out: 1'b0, oe: 1'b0};
      end
   end

   // Register the output group so the pin never glitches.
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         phase_reg     <= 2'h0;
         clkOut_reg    <= 1'b0;
         clkOutAct_reg <= 1'b0;
         secPin_reg    <= '{out: 1'b0, oe: 1'b0};
      end else begin
         phase_reg     <= phase_next;
         clkOut_reg    <= clkOut_next;
         clkOutAct_reg <= clkOutAllowed;
         secPin_reg    <= secPin_next;
      end
   end

   assign secondOscPin    = secPin_reg;
   assign clockOutActive  = clkOutAct_reg;
   assign cpuExecTick     = cpuTick && !idleMode;
   assign oscRunning      = (st_reg == oscsel_pkg::ST_RUN) || (st_reg == oscsel_pkg::ST_START);
   assign secondPinIsPort = isExt && !clkOutAct_reg;

   // ------------------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------------------
   AST_STRAP_FIXED: assert property (@(posedge core_clk) disable iff (rst)
      (st_reg != oscsel_pkg::ST_LOAD) |=> $stable(oscType_reg) && $stable(halve_reg))
      else $error("Oscillator option changed after it was loaded.");

   AST_CLKOUT_OPTION: assert property (@(posedge core_clk) disable iff (rst)
      clkOutAct_reg |-> rcOrExt && secPin_reg.oe)
      else $error("Clock output active with an option that has none.");

   AST_EXT_RELEASE: assert property (@(posedge core_clk) disable iff (rst)
      (isExt && !clkOutAllowed) |=> (secPin_reg == $past(portDrive)))
      else $error("Second oscillator pin not handed to the port.");

   AST_CLKOUT_IDLE: assert property (@(posedge core_clk) disable iff (rst)
      (clockOutEnable && rcOrExt && st_reg == oscsel_pkg::ST_RUN) |=> secPin_reg.oe
      && (secPin_reg.out == clkOut_reg))
      else $error("Clock output missing while enabled and running.");

   AST_CLKOUT_RATIO: assert property (@(posedge core_clk) disable iff (rst)
      clkOutAllowed |=> ((clkOut_reg != $past(clkOut_reg))
      == $past(cpuTick && phase_reg == 2'h2)))
      else $error("Clock output edge not on every third CPU strobe.");

   AST_WAKE_COUNT: assert property (@(posedge core_clk) disable iff (rst)
      ($past(st_reg) == oscsel_pkg::ST_START && st_reg == oscsel_pkg::ST_RUN)
      |-> ($past(startCnt_reg) == (isCrystal ? 11'h3FF : 11'h0FF)))
      else $error("Execution resumed after the wrong start-up count.");

   AST_XTAL_NO_CLKOUT: assert property (@(posedge core_clk) disable iff (rst)
      (isCrystal && st_reg != oscsel_pkg::ST_LOAD) |=> !clkOutAct_reg && !secPin_reg.oe)
      else $error("Clock output driven with a crystal option.");

   COV_CLKOUT_IDLE: cover property (@(posedge core_clk) disable iff (rst)
      clkOutAct_reg && idleMode && $rose(clkOut_reg));
   COV_WAKE: cover property (@(posedge core_clk) disable iff (rst)
      $past(st_reg) == oscsel_pkg::ST_START && st_reg == oscsel_pkg::ST_RUN);
   COV_EXT_PORT: cover property (@(posedge core_clk) disable iff (rst)
      secondPinIsPort && secPin_reg.oe);

endmodule
`default_nettype wire

// >>> sim/oscillator_select_clock_output_bench.sv
/*
 Self-checking bench of the oscillator select and clock output block.
 Assumes the block's package, defines header and the sync device model.
*/
`timescale 1ns/1ps
`default_nettype none
`include "oscsel_defines.svh"

module oscillator_select_clock_output_bench;
   // -----------------------------------------------------------------------
   // Stimulus, design and partner
   // -----------------------------------------------------------------------
   logic                       core_clk;
   logic                       rst;
   logic [2:0]                 oscTypeStrap;
   logic                       machineCycleHalving;
   logic [7:0]                 cpuClockDivider;
   logic                       clockOutEnable;
   logic                       idleMode;
   logic                       powerDownReq;
   logic                       wakeReq;
   oscsel_pkg::oscsel_pin_type portDrive;
   oscsel_pkg::oscsel_pin_type secondOscPin;
   logic                       cpuTick;
   logic                       cpuExecTick;
   logic                       oscRunning;
   logic                       secondPinIsPort;
   logic                       clockOutActive;
   logic [7:0]                 lastPeriod;
   int                         miscompares;
   int                         testsRun;

   oscsel_top dut_u (.core_clk(core_clk), .rst(rst), .oscTypeStrap(oscTypeStrap),
      .machineCycleHalving(machineCycleHalving), .cpuClockDivider(cpuClockDivider),
      .clockOutEnable(clockOutEnable), .idleMode(idleMode), .powerDownReq(powerDownReq),
      .wakeReq(wakeReq), .portDrive(portDrive), .secondOscPin(secondOscPin),
      .cpuTick(cpuTick), .cpuExecTick(cpuExecTick), .oscRunning(oscRunning),
      .secondPinIsPort(secondPinIsPort), .clockOutActive(clockOutActive));

   oscsel_sync_device partner_u (.core_clk(core_clk), .rst(rst), .pin(secondOscPin),
      .cpuTick(cpuTick), .lastPeriod(lastPeriod));

   // The oscillator stands in for the outside clock source on the input pin.
   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end

   // -----------------------------------------------------------------------
   // Checking tasks
   // -----------------------------------------------------------------------
   task automatic report_and_stop();
      $display("Comparisons %0d, mismatches %0d", testsRun, miscompares);
      if (miscompares == 0 && testsRun > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   task automatic check_bit(input string what, input logic exp, input logic got);
      testsRun++;
      if (got !== exp) begin
         $display("Error %s expected %b seen %b", what, exp, got);
         miscompares++;
      end
   endtask

   task automatic check_num(input string what, input logic [15:0] exp, input logic [15:0] got);
      testsRun++;
      if (got !== exp) begin
         $display("Error %s expected %0d seen %0d", what, exp, got);
         miscompares++;
      end
   endtask

   // A restart count is judged within a small window around the start-up figure.
   task automatic check_range(input string what, input int lo, input int hi, input int got);
      testsRun++;
      if (got < lo || got > hi) begin
         $display("Error %s expected %0d to %0d seen %0d", what, lo, hi, got);
         miscompares++;
      end
   endtask

   // Counts falling edges up to the next CPU tick; a lost tick ends the run.
   task automatic wait_tick(output int n);
      n = 0;
      do begin
         @(negedge core_clk);
         n++;
         if (n > 1200) begin
            $display("Error cpuTick expected a pulse seen none");
            miscompares++;
            report_and_stop();
         end
      end while (cpuTick !== 1'b1);
   endtask

   // Straps must be valid at the first edge after release, so they go with reset.
   task automatic do_reset(input logic [2:0] strap, input logic halv);
      @(posedge core_clk);
      rst <= 1'b1;
      oscTypeStrap <= strap;
      machineCycleHalving <= halv;
      repeat (3) @(posedge core_clk);
      rst <= 1'b0;
      repeat (2) @(posedge core_clk);
   endtask

   // -----------------------------------------------------------------------
   // Scenarios
   // -----------------------------------------------------------------------
   task automatic test_divider();
      logic [7:0] nTab [4] = '{8'h00, 8'h01, 8'hFF, 8'h00};
      logic       hTab [4] = '{1'b0, 1'b0, 1'b0, 1'b1};
      int         eTab [4] = '{1, 4, 512, 2};
      int         n;
      for (int i = 0; i < 4; i++) begin
         do_reset(`OSCSEL_STRAP_RC, hTab[i]);
         cpuClockDivider <= nTab[i];
         wait_tick(n);
         wait_tick(n);
         check_num("cpuTick period", eTab[i][15:0], n[15:0]);
         check_bit("cpuExecTick", 1'b1, cpuExecTick);
      end
      $display("Divider test done");
   endtask

   task automatic test_clock_out();
      logic [2:0] straps [2] = '{`OSCSEL_STRAP_RC, `OSCSEL_STRAP_EXT};
      int         n;
      for (int i = 0; i < 2; i++) begin
         do_reset(straps[i], 1'b0);
         cpuClockDivider <= 8'h01;
         clockOutEnable <= 1'b1;
         idleMode <= 1'b1;
         repeat (100) @(posedge core_clk);
         @(negedge core_clk);
         check_bit("clockOutActive", 1'b1, clockOutActive);
         check_bit("pin drive enable", 1'b1, secondOscPin.oe);
         check_num("clock out period", 16'h0006, {8'h00, lastPeriod});
         // The CPU strobe keeps running in Idle, only the execution strobe is held off.
         wait_tick(n);
         check_bit("cpuExecTick in Idle", 1'b0, cpuExecTick);
         @(posedge core_clk);
         clockOutEnable <= 1'b0;
         repeat (3) @(posedge core_clk);
         idleMode <= 1'b0;
         @(negedge core_clk);
         check_bit("clockOutActive off", 1'b0, clockOutActive);
         check_bit("pin is port after clock out", i == 1, secondPinIsPort);
      end
      $display("Clock output test done");
   endtask

   // A strap change after reset must not unlock the output on a crystal option.
   task automatic test_crystal();
      logic [2:0] s [3] = '{`OSCSEL_STRAP_LOW, `OSCSEL_STRAP_MED, `OSCSEL_STRAP_HIGH};
      for (int i = 0; i < 3; i++) begin
         do_reset(s[i], 1'b0);
         oscTypeStrap <= `OSCSEL_STRAP_RC;
         cpuClockDivider <= 8'h00;
         clockOutEnable <= 1'b1;
         for (int c = 0; c < 40; c++) begin
            @(negedge core_clk);
            check_bit("crystal clockOutActive", 1'b0, clockOutActive);
         end
         check_bit("crystal pin drive enable", 1'b0, secondOscPin.oe);
         @(posedge core_clk);
         clockOutEnable <= 1'b0;
      end
      $display("Crystal test done");
   endtask

   task automatic test_port_pin();
      do_reset(`OSCSEL_STRAP_EXT, 1'b0);
      for (int v = 0; v < 4; v++) begin
         @(posedge core_clk);
         portDrive <= oscsel_pkg::oscsel_pin_type'(v[1:0]);
         @(posedge core_clk);
         @(negedge core_clk);
         check_num("second pin", {14'h0000, v[1:0]}, {14'h0000, secondOscPin});
      end
      check_bit("pin is port", 1'b1, secondPinIsPort);
      do_reset(`OSCSEL_STRAP_RC, 1'b0);
      @(negedge core_clk);
      check_bit("RC pin is port", 1'b0, secondPinIsPort);
      $display("Port pin test done");
   endtask

   task automatic test_power_down();
      logic [2:0] straps [2] = '{`OSCSEL_STRAP_RC, `OSCSEL_STRAP_LOW};
      int         counts [2] = '{`OSCSEL_START_RCEXT_CLKS, `OSCSEL_START_XTAL_CLKS};
      int         n;
      for (int i = 0; i < 2; i++) begin
         do_reset(straps[i], 1'b0);
         cpuClockDivider <= 8'h00;
         powerDownReq <= 1'b1;
         @(posedge core_clk);
         powerDownReq <= 1'b0;
         @(negedge core_clk);
         check_bit("oscRunning in power down", 1'b0, oscRunning);
         @(posedge core_clk);
         wakeReq <= 1'b1;
         @(posedge core_clk);
         wakeReq <= 1'b0;
         @(negedge core_clk);
         check_bit("oscRunning in restart", 1'b1, oscRunning);
         wait_tick(n);
         check_range("restart cycles", counts[i] - 2, counts[i] + 3, n);
      end
      $display("Power down test done");
   endtask

   // -----------------------------------------------------------------------
   // Main sequence
   // -----------------------------------------------------------------------
   initial begin
      rst = 1'b1;
      oscTypeStrap = `OSCSEL_STRAP_RC;
      machineCycleHalving = 1'b0;
      cpuClockDivider = 8'h00;
      clockOutEnable = 1'b0;
      idleMode = 1'b0;
      powerDownReq = 1'b0;
      wakeReq = 1'b0;
      portDrive = 2'h0;
      miscompares = 0;
      testsRun = 0;
      test_divider();
      test_clock_out();
      test_crystal();
      test_port_pin();
      test_power_down();
      report_and_stop();
   end
endmodule
`default_nettype wire

// >>> sim/oscsel_sync_device.sv
/*
 Model of an outside device that synchronises to the clock output pin.
 Assumes the pin drive struct and the CPU clock strobe of the block, both on core_clk.
*/
`timescale 1ns/1ps
`default_nettype none

module oscsel_sync_device (
   input  wire logic                       core_clk,
   input  wire logic                       rst,
   input  wire oscsel_pkg::oscsel_pin_type pin,
   input  wire logic                       cpuTick,
   output logic [7:0]                      lastPeriod
);
   // -----------------------------------------------------------------------
   // Line level and period measurement
   // -----------------------------------------------------------------------
   logic       wireLevel;
   logic       level_reg;
   logic       driven_reg;
   logic [7:0] count_reg;

   // The released pin has no pull, so the line shows the inverse of the last driven level.
   assign wireLevel = pin.oe ? pin.out : ~driven_reg;

   // Counts CPU ticks between rising edges; edges only count while the block drives.
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         level_reg  <= 1'b0;
         driven_reg <= 1'b0;
         count_reg  <= 8'h00;
         lastPeriod <= 8'h00;
      end else begin
         level_reg <= wireLevel;
         if (pin.oe) begin
            driven_reg <= pin.out;
         end
         if (pin.oe && wireLevel && !level_reg) begin
            lastPeriod <= count_reg + {7'h00, cpuTick};
            count_reg  <= 8'h00;
         end else begin
            count_reg <= count_reg + {7'h00, cpuTick};
         end
      end
   end
endmodule
`default_nettype wire
